// ### include/adc_ref_touch_defines.svh
// Contract
// - Bit 4 set selects internal reference
// - Wait settle delay after reference power-up
// - Bit 1 powers reference down between conversions
// - External mode keeps internal reference off
// - Auto mode: reference on only during conversion
// - Bit 0 selects 1.2 V or 2.5 V
// - Reference fields read back as written
// - Precharge panel for selected time before sensing
// - Wait selected sense time for touch
// - Touch: drive panel, stabilize, then sample
`ifndef ADC_REF_TOUCH_DEFINES_SVH
`define ADC_REF_TOUCH_DEFINES_SVH

`define CLK_PERIOD_NS 25
`define US_CYCLES (1000 / `CLK_PERIOD_NS)

`define REG_PAGE 1'b1
`define REF_CTRL_ADDR 4'h3
`define TOUCH_TIMING_ADDR 4'h5

`define REF_CTRL_RESET 5'h02
`define TOUCH_TIMING_RESET 6'h00
`define REF_INT_BIT 4
`define REF_DLY_HI 3
`define REF_DLY_LO 2
`define REF_PDN_BIT 1
`define REF_VSEL_BIT 0
`define PRE_HI 5
`define PRE_LO 3
`define SNS_HI 2
`define SNS_LO 0

`define SETTLE_0_US 17'd0
`define SETTLE_1_US 17'd100
`define SETTLE_2_US 17'd500
`define SETTLE_3_US 17'd1000

`define PRE_0_US 17'd20
`define PRE_1_US 17'd84
`define PRE_2_US 17'd276
`define PRE_3_US 17'd340
`define PRE_4_US 17'd1044
`define PRE_5_US 17'd1108
`define PRE_6_US 17'd1300
`define PRE_7_US 17'd1364

`define SNS_0_US 17'd32
`define SNS_1_US 17'd96
`define SNS_2_US 17'd544
`define SNS_3_US 17'd608
`define SNS_4_US 17'd2080
`define SNS_5_US 17'd2144
`define SNS_6_US 17'd2592
`define SNS_7_US 17'd2656

`define PANEL_0_US 17'd0
`define PANEL_1_US 17'd100
`define PANEL_2_US 17'd500
`define PANEL_3_US 17'd1000
`define PANEL_4_US 17'd5000
`define PANEL_5_US 17'd10000
`define PANEL_6_US 17'd50000
`define PANEL_7_US 17'd100000

`endif

// ### include/adc_ref_touch_pkg.sv
package adc_ref_touch_pkg;
    typedef logic [16:0] us_count_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETTLE = 3'b001,
        ST_PRECHG = 3'b010,
        ST_SENSE = 3'b011,
        ST_DRIVE = 3'b100,
        ST_SAMPLE = 3'b101,
        ST_CONVERT = 3'b110
    } seq_state_t;
endpackage

// ### include/delay_timer_if.sv
`timescale 1ns/10ps
`default_nettype none
interface delay_timer_if;
    logic start;
    adc_ref_touch_pkg::us_count_t load_us;
    logic done;
    logic busy;
    modport ctrl(output start, output load_us, input done, input busy);
    modport timer(input start, input load_us, output done, output busy);
endinterface
`default_nettype wire

// ### hdl/us_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ref_touch_defines.svh"
module us_delay_timer
    import adc_ref_touch_pkg::*;
#(
    parameter logic [15:0] TICK_CYCLES = 16'(`US_CYCLES)
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    delay_timer_if.timer tmr
);
    logic running_q;
    us_count_t cnt_q;
    logic [15:0] pre_q;
    wire logic tick_wrap;

    assign tick_wrap = (pre_q == TICK_CYCLES - 16'h0001);
    // Zero load finishes one cycle after start
    assign tmr.done = running_q && (cnt_q == 17'h00000);
    assign tmr.busy = running_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            running_q <= 1'b0;
            cnt_q <= 17'h00000;
            pre_q <= 16'h0000;
        end else if (tmr.start) begin
            running_q <= 1'b1;
            cnt_q <= tmr.load_us;
            pre_q <= 16'h0000;
        end else if (tmr.done) begin
            running_q <= 1'b0;
        end else if (running_q) begin
            pre_q <= tick_wrap ? 16'h0000 : pre_q + 16'h0001;
            if (tick_wrap) begin
                cnt_q <= cnt_q - 17'h00001;
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/adc_ref_touch_timing_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ref_touch_defines.svh"
module adc_ref_touch_timing_ctrl
    import adc_ref_touch_pkg::*;
#(
    // Shrink for simulation; all long waits scale with it
    parameter logic [15:0] TICK_CYCLES = 16'(`US_CYCLES)
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic i_reg_page,
    input wire logic [3:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic i_self_ctrl,
    input wire logic [2:0] i_panel_settle_sel,
    input wire logic i_conv_req,
    input wire logic i_conv_done,
    input wire logic i_pen_sense,
    output logic o_int_ref_sel,
    output logic o_ref_voltage_sel,
    output logic o_int_ref_pwr,
    output logic o_ref_settled,
    output logic o_precharge_en,
    output logic o_sense_en,
    output logic o_panel_drv_en,
    output logic o_sample_start,
    output logic o_no_touch,
    output logic o_busy
);
    delay_timer_if tmr ();

    logic [4:0] ref_ctrl_q;
    logic [5:0] touch_timing_q;
    logic [15:0] rdata_q;
    seq_state_t state_q;
    seq_state_t state_d;
    logic settled_q;
    logic no_touch_q;
    logic pen_s1_q;
    logic pen_s2_q;
    logic pen_s3_q;
    logic pen_lvl_q;

    wire logic page_hit;
    wire logic ref_sel;
    wire logic tdt_sel;
    wire logic ref_wr;
    wire logic tdt_wr;
    wire logic ref_int;
    wire logic ref_auto_powerdown;
    wire logic [1:0] ref_settle_delay_sel;
    wire logic [2:0] precharge_sel;
    wire logic [2:0] sense_time_sel;
    wire logic ref_pwr;
    wire logic need_settle;
    wire seq_state_t first_meas;
    wire logic timed_next;
    wire logic [15:0] rdata_d;

    function automatic us_count_t settle_us(input logic [1:0] code);
        case (code)
            2'b00: settle_us = `SETTLE_0_US;
            2'b01: settle_us = `SETTLE_1_US;
            2'b10: settle_us = `SETTLE_2_US;
            default: settle_us = `SETTLE_3_US;
        endcase
    endfunction

    function automatic us_count_t precharge_us(input logic [2:0] code);
        case (code)
            3'b000: precharge_us = `PRE_0_US;
            3'b001: precharge_us = `PRE_1_US;
            3'b010: precharge_us = `PRE_2_US;
            3'b011: precharge_us = `PRE_3_US;
            3'b100: precharge_us = `PRE_4_US;
            3'b101: precharge_us = `PRE_5_US;
            3'b110: precharge_us = `PRE_6_US;
            default: precharge_us = `PRE_7_US;
        endcase
    endfunction

    function automatic us_count_t sense_us(input logic [2:0] code);
        case (code)
            3'b000: sense_us = `SNS_0_US;
            3'b001: sense_us = `SNS_1_US;
            3'b010: sense_us = `SNS_2_US;
            3'b011: sense_us = `SNS_3_US;
            3'b100: sense_us = `SNS_4_US;
            3'b101: sense_us = `SNS_5_US;
            3'b110: sense_us = `SNS_6_US;
            default: sense_us = `SNS_7_US;
        endcase
    endfunction

    function automatic us_count_t panel_us(input logic [2:0] code);
        case (code)
            3'b000: panel_us = `PANEL_0_US;
            3'b001: panel_us = `PANEL_1_US;
            3'b010: panel_us = `PANEL_2_US;
            3'b011: panel_us = `PANEL_3_US;
            3'b100: panel_us = `PANEL_4_US;
            3'b101: panel_us = `PANEL_5_US;
            3'b110: panel_us = `PANEL_6_US;
            default: panel_us = `PANEL_7_US;
        endcase
    endfunction

    assign page_hit = (i_reg_page == `REG_PAGE);
    assign ref_sel = page_hit && (i_reg_addr == `REF_CTRL_ADDR);
    assign tdt_sel = page_hit && (i_reg_addr == `TOUCH_TIMING_ADDR);
    assign ref_wr = i_reg_wr && ref_sel;
    assign tdt_wr = i_reg_wr && tdt_sel;

    assign ref_int = ref_ctrl_q[`REF_INT_BIT];
    assign ref_auto_powerdown = ref_ctrl_q[`REF_PDN_BIT];
    assign ref_settle_delay_sel = ref_ctrl_q[`REF_DLY_HI:`REF_DLY_LO];
    assign precharge_sel = touch_timing_q[`PRE_HI:`PRE_LO];
    assign sense_time_sel = touch_timing_q[`SNS_HI:`SNS_LO];

    assign rdata_d = ref_sel ? {11'h000, ref_ctrl_q} :
                     tdt_sel ? {10'h000, touch_timing_q} : 16'h0000;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_ctrl_q <= `REF_CTRL_RESET;
            touch_timing_q <= `TOUCH_TIMING_RESET;
            rdata_q <= 16'h0000;
        end else begin
            if (ref_wr) begin
                ref_ctrl_q <= i_reg_wdata[4:0];
            end
            if (tdt_wr) begin
                touch_timing_q <= i_reg_wdata[5:0];
            end
            if (i_reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign o_reg_rdata = rdata_q;

    // Three stages; first stage feeds only the second
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pen_s1_q <= 1'b0;
            pen_s2_q <= 1'b0;
            pen_s3_q <= 1'b0;
            pen_lvl_q <= 1'b0;
        end else begin
            pen_s1_q <= i_pen_sense;
            pen_s2_q <= pen_s1_q;
            pen_s3_q <= pen_s2_q;
            if (pen_s2_q == pen_s3_q) begin
                pen_lvl_q <= pen_s3_q;
            end
        end
    end

    assign o_int_ref_sel = ref_int;
    assign o_ref_voltage_sel = ref_ctrl_q[`REF_VSEL_BIT];
    assign ref_pwr = ref_int && (!ref_auto_powerdown || (state_q != ST_IDLE));
    assign o_int_ref_pwr = ref_pwr;

    assign need_settle = ref_int && !settled_q;
    assign first_meas = i_self_ctrl ? ST_PRECHG : ST_SAMPLE;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (i_conv_req) begin
                    state_d = need_settle ? ST_SETTLE : first_meas;
                end
            end
            ST_SETTLE: begin
                if (tmr.done) begin
                    state_d = first_meas;
                end
            end
            ST_PRECHG: begin
                if (tmr.done) begin
                    state_d = ST_SENSE;
                end
            end
            ST_SENSE: begin
                if (tmr.done) begin
                    state_d = pen_lvl_q ? ST_DRIVE : ST_IDLE;
                end
            end
            ST_DRIVE: begin
                if (tmr.done) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                state_d = ST_CONVERT;
            end
            ST_CONVERT: begin
                if (i_conv_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign timed_next = (state_d == ST_SETTLE) || (state_d == ST_PRECHG) ||
                        (state_d == ST_SENSE) || (state_d == ST_DRIVE);
    assign tmr.start = (state_d != state_q) && timed_next;
    assign tmr.load_us = (state_d == ST_SETTLE) ? settle_us(ref_settle_delay_sel) :
                         (state_d == ST_PRECHG) ? precharge_us(precharge_sel) :
                         (state_d == ST_SENSE) ? sense_us(sense_time_sel) :
                         panel_us(i_panel_settle_sel);

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            settled_q <= 1'b0;
            no_touch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // lost whenever the reference is off
            if (!ref_pwr) begin
                settled_q <= 1'b0;
            end else if ((state_q == ST_SETTLE) && tmr.done) begin
                settled_q <= 1'b1;
            end
            no_touch_q <= (state_q == ST_SENSE) && tmr.done && !pen_lvl_q;
        end
    end

    assign o_ref_settled = settled_q;
    assign o_precharge_en = (state_q == ST_PRECHG);
    assign o_sense_en = (state_q == ST_SENSE);
    assign o_panel_drv_en = (state_q == ST_DRIVE) || (state_q == ST_SAMPLE) ||
                            ((state_q == ST_CONVERT) && i_self_ctrl);
    assign o_sample_start = (state_q == ST_SAMPLE);
    assign o_no_touch = no_touch_q;
    assign o_busy = (state_q != ST_IDLE);

    us_delay_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .tmr(tmr)
    );

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_src_write;
        ref_wr |=> (o_int_ref_sel == $past(i_reg_wdata[4]));
    endproperty
    a_src_write: assert property (p_src_write) else $error("ref source not updated");

    property p_ext_off;
        !o_int_ref_sel |-> !o_int_ref_pwr;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("internal ref on in external mode");

    property p_always_on;
        (ref_int && !ref_auto_powerdown) |-> o_int_ref_pwr;
    endproperty
    a_always_on: assert property (p_always_on) else $error("ref off with powerdown clear");

    property p_auto_off;
        (ref_int && ref_auto_powerdown && !o_busy) |-> !o_int_ref_pwr;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("ref on between conversions");

    property p_vsel_write;
        ref_wr |=> (o_ref_voltage_sel == $past(i_reg_wdata[0]));
    endproperty
    a_vsel_write: assert property (p_vsel_write) else $error("voltage select wrong");

    property p_ref_readback;
        (ref_wr && !i_reg_rd) ##1 !i_reg_wr ##1 (i_reg_rd && ref_sel && !i_reg_wr)
            |=> (o_reg_rdata == {11'h000, $past(i_reg_wdata[4:0], 3)});
    endproperty
    a_ref_readback: assert property (p_ref_readback) else $error("ref readback wrong");

    property p_tdt_reserved;
        (i_reg_rd && tdt_sel) |=> (o_reg_rdata[15:6] == 10'h000);
    endproperty
    a_tdt_reserved: assert property (p_tdt_reserved) else $error("reserved bits not zero");

    property p_sample_settled;
        (o_sample_start && o_int_ref_sel) |-> o_ref_settled && o_int_ref_pwr;
    endproperty
    a_sample_settled: assert property (p_sample_settled) else $error("sampled unsettled");

    property p_settle_first;
        (i_conv_req && !o_busy && need_settle) |=> (state_q == ST_SETTLE) && !o_sample_start;
    endproperty
    a_settle_first: assert property (p_settle_first) else $error("settle skipped");

    property p_sense_after_pre;
        $fell(o_precharge_en) && !$fell(o_busy) |-> o_sense_en;
    endproperty
    a_sense_after_pre: assert property (p_sense_after_pre) else $error("no sense");

    property p_sense_result;
        (o_sense_en && tmr.done) |=> ($past(pen_lvl_q) ? o_panel_drv_en : o_no_touch);
    endproperty
    a_sense_result: assert property (p_sense_result) else $error("sense outcome wrong");

    property p_drive_before_sample;
        (o_sample_start && i_self_ctrl) |-> $past(state_q == ST_DRIVE) && o_panel_drv_en;
    endproperty
    a_drive_before_sample: assert property (p_drive_before_sample) else $error("no drive");

    c_settle: cover property ((state_q == ST_SETTLE) ##1 (state_q != ST_SETTLE));
    c_touch: cover property (o_sense_en ##1 o_panel_drv_en);
    c_no_touch: cover property (o_no_touch);
    c_convert: cover property (o_sample_start ##[1:20] i_conv_done);
endmodule
`default_nettype wire

// ### testbench/reg_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
    input wire logic i_sys_clk,
    input wire logic [15:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic o_reg_page,
    output logic [3:0] o_reg_addr,
    output logic [15:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_page = 1'b0;
        o_reg_addr = 4'h0;
        o_reg_wdata = 16'h0000;
    end

    // One strobe cycle, then the bus shows inverted values so stray sampling shows up
    task automatic access(input logic w, input logic pg, input logic [3:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        @(posedge i_sys_clk);
        o_reg_wr <= w;
        o_reg_rd <= ~w;
        o_reg_page <= pg;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_sys_clk);
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        o_reg_page <= ~pg;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
        @(negedge i_sys_clk);
        q = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/adc_ref_touch_timing_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module adc_ref_touch_timing_ctrl_tb_top;
    typedef struct packed {
        logic w;
        logic pg;
        logic [3:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_t;
    logic clk, rst_b, wr, rd, page, self, req, done, pen;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, q, shadow;
    logic [2:0] psel;
    logic int_sel, vsel, pwr, settled, pre_en, sns_en, drv_en, smp, nt, busy, pwr_on;
    int err_count, tests_run, t_smp, n_pre, n_sns, n_drv, n_nt, n_smp;
    int settle_us [4] = '{0, 100, 500, 1000};
    int pre_us [8] = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
    int sns_us [8] = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};
    row_t rows [7] = '{
        '{1'b1, 1'b1, 4'h3, 16'hFFFF, 16'h001F},
        '{1'b1, 1'b1, 4'h5, 16'hFFFF, 16'h003F},
        '{1'b1, 1'b1, 4'h3, 16'h0013, 16'h0013},
        '{1'b1, 1'b0, 4'h3, 16'h0000, 16'h0000},
        '{1'b0, 1'b1, 4'h3, 16'h0000, 16'h0013},
        '{1'b1, 1'b1, 4'h4, 16'hFFFF, 16'h0000},
        '{1'b1, 1'b1, 4'h5, 16'h002A, 16'h002A}
    };

    // Shortened tick keeps the longest waits to a few thousand cycles
    adc_ref_touch_timing_ctrl #(.TICK_CYCLES(16'h0001)) adc_ref_touch_timing_ctrl_i (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_page(page), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_self_ctrl(self), .i_panel_settle_sel(psel), .i_conv_req(req),
        .i_conv_done(done), .i_pen_sense(pen), .o_int_ref_sel(int_sel),
        .o_ref_voltage_sel(vsel), .o_int_ref_pwr(pwr), .o_ref_settled(settled),
        .o_precharge_en(pre_en), .o_sense_en(sns_en), .o_panel_drv_en(drv_en),
        .o_sample_start(smp), .o_no_touch(nt), .o_busy(busy)
    );
    reg_host_model reg_host_model_i (
        .i_sys_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_page(page), .o_reg_addr(addr), .o_reg_wdata(wdata)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        reg_host_model_i.access(1'b1, 1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic pg, input logic [3:0] a, input logic [15:0] e);
        reg_host_model_i.access(1'b0, pg, a, 16'h0000, q);
        check("rdata", 32'(q), 32'(e));
    endtask

    // Conversion done is answered one cycle after the sample pulse
    task automatic run_conv(input logic sc, input logic pn, input logic [2:0] ps);
        logic sl;
        int idle_n;
        t_smp = 0;
        n_pre = 0;
        n_sns = 0;
        n_drv = 0;
        n_nt = 0;
        n_smp = 0;
        idle_n = 0;
        pwr_on = 1'b0;
        @(posedge clk);
        req <= 1'b1;
        self <= sc;
        pen <= pn;
        psel <= ps;
        @(posedge clk);
        req <= 1'b0;
        for (int t = 1; t < 20000; t++) begin
            @(negedge clk);
            if (pre_en === 1'b1) n_pre++;
            if (sns_en === 1'b1) n_sns++;
            if (nt === 1'b1) n_nt++;
            if (drv_en === 1'b1 && smp !== 1'b1 && n_smp == 0) n_drv++;
            if (smp === 1'b1) begin
                t_smp = t;
                n_smp++;
            end
            pwr_on = pwr_on | pwr;
            sl = smp;
            if (busy !== 1'b1) idle_n++;
            if (idle_n == 2) break;
            @(posedge clk);
            done <= sl;
        end
        // A conversion that never returns to idle counts as a mismatch
        check("conv end", 32'(idle_n), 32'd2);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        self = 1'b0;
        req = 1'b0;
        done = 1'b0;
        pen = 1'b0;
        psel = 3'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(1'b1, 4'h3, 16'h0002);
        rdchk(1'b1, 4'h5, 16'h0000);
        check("pwr", 32'(pwr), 32'h0);
        $display("test reset done");
        shadow = 16'h0002;
        foreach (rows[i]) begin
            reg_host_model_i.access(rows[i].w, rows[i].pg, rows[i].a, rows[i].d, q);
            if (rows[i].w && rows[i].pg && rows[i].a == 4'h3) shadow = rows[i].d & 16'h001F;
            rdchk(rows[i].pg, rows[i].a, rows[i].e);
            check("int_sel", 32'(int_sel), 32'(shadow[4]));
            check("vsel", 32'(vsel), 32'(shadow[0]));
        end
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wreg(4'h3, {11'h000, k[1], 2'b00, k[0], 1'b0});
            check("pwr mode", 32'(pwr), 32'(k == 2));
        end
        for (int k = 0; k < 4; k++) begin
            wreg(4'h3, 16'h0012 | 16'(k << 2));
            run_conv(1'b0, 1'b0, 3'h0);
            check("settle", 32'(t_smp), 32'(settle_us[k] + 2));
            check("pwr on", 32'(pwr_on), 32'h1);
            check("pwr off", 32'(pwr), 32'h0);
            check("settled", 32'(settled), 32'h0);
        end
        wreg(4'h3, 16'h0014);
        run_conv(1'b0, 1'b0, 3'h0);
        check("first settle", 32'(t_smp), 32'd102);
        run_conv(1'b0, 1'b0, 3'h0);
        check("no resettle", 32'(t_smp), 32'd1);
        check("pwr stays", 32'(pwr), 32'h1);
        wreg(4'h3, 16'h0002);
        run_conv(1'b0, 1'b0, 3'h0);
        check("ext start", 32'(t_smp), 32'd1);
        check("ext pwr", 32'(pwr_on), 32'h0);
        $display("test reference done");
        for (int k = 0; k < 8; k++) begin
            wreg(4'h5, 16'(k * 8 + 7 - k));
            run_conv(1'b1, 1'b0, 3'h0);
            check("precharge", 32'(n_pre), 32'(pre_us[k] + 1));
            check("sense", 32'(n_sns), 32'(sns_us[7 - k] + 1));
            check("no touch", 32'(n_nt), 32'd1);
            check("no sample", 32'(n_smp), 32'd0);
        end
        wreg(4'h5, 16'h0000);
        run_conv(1'b1, 1'b1, 3'h1);
        check("drive", 32'(n_drv), 32'd101);
        check("sample at", 32'(t_smp), 32'd156);
        check("touch", 32'(n_nt), 32'd0);
        $display("test touch done");
        // Non-reset contents so the second reset is visible
        wreg(4'h3, 16'h001D);
        wreg(4'h5, 16'h0015);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(1'b1, 4'h3, 16'h0002);
        rdchk(1'b1, 4'h5, 16'h0000);
        check("reset pwr", 32'(pwr), 32'h0);
        check("reset vsel", 32'(vsel), 32'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
